// ===== hdl/cdrc_event_det.sv
// Debug event detector: qualifies and prioritises the four event sources.
`timescale 1ns/100ps
module cdrc_event_det
    import cdrc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 enable,
    input  wire logic                 brk_in,
    input  wire logic                 instr_valid,
    input  wire logic                 instr_is_debug,
    input  wire logic                 instr_is_cr_move,
    input  wire logic [CR_ADDR_W-1:0] instr_cr_addr,
    input  wire logic                 trg_hit,
    cdrc_evt_if.det                   evt
);
    typedef struct packed {
        logic      valid;
        cdrc_src_t src;
        logic      brk_d;
    } cdrc_det_st_t;

    cdrc_det_st_t st_r;
    cdrc_det_st_t st_nxt;

    function automatic logic is_dbg_cr(input logic [CR_ADDR_W-1:0] a);
        return (a >= DBG_CR_LO) && (a <= DBG_CR_HI);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Detection only observes the core, it never stalls it.
    always_comb begin
        logic ext_ev;
        logic sw_ev;
        logic cr_ev;
        ext_ev = brk_in && !st_r.brk_d;
        sw_ev  = instr_valid && instr_is_debug;
        cr_ev  = instr_valid && instr_is_cr_move && !is_dbg_cr(instr_cr_addr);
        st_nxt       = st_r;
        st_nxt.brk_d = brk_in;
        st_nxt.valid = 1'b0;
        st_nxt.src   = CDRC_SRC_NONE;
        if (enable) begin
            if (ext_ev) begin
                st_nxt.valid = 1'b1;
                st_nxt.src   = CDRC_SRC_EXT;
            end else if (sw_ev) begin
                st_nxt.valid = 1'b1;
                st_nxt.src   = CDRC_SRC_SW;
            end else if (cr_ev) begin
                st_nxt.valid = 1'b1;
                st_nxt.src   = CDRC_SRC_CR;
            end else if (trg_hit) begin
                st_nxt.valid = 1'b1;
                st_nxt.src   = CDRC_SRC_TRG;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst_b == RST_LVL) begin
            st_r <= '{valid: 1'b0, src: CDRC_SRC_NONE, brk_d: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign evt.valid = st_r.valid;
    assign evt.src   = st_r.src;
endmodule // cdrc_event_det

// ===== hdl/cdrc_evt_if.sv
// Interface carrying detected debug events from the detector to the controller.
`timescale 1ns/100ps
interface cdrc_evt_if;
    import cdrc_pkg::*;
    logic      valid;
    cdrc_src_t src;
    modport det (output valid, output src);
    modport ctl (input valid, input src);
endinterface

// ===== hdl/cdrc_pkg.sv
// Package with constants and types of the core debug run control block.
package cdrc_pkg;
    localparam int          ADDR_W      = 32;
    localparam int          DATA_W      = 32;
    localparam int          CR_ADDR_W   = 16;
    localparam logic [15:0] DBG_CR_LO   = 16'hf000;
    localparam logic [15:0] DBG_CR_HI   = 16'hfdff;
    // Layout of one action programming word.
    localparam int          ACT_W       = 7;
    localparam int          ACT_BRKOUT  = 0;
    localparam int          ACT_SUSPSET = 1;
    localparam int          ACT_SUSPVAL = 2;
    localparam int          ACT_HALT    = 3;
    localparam int          ACT_TRAP    = 4;
    localparam int          ACT_INT     = 5;
    localparam int          ACT_CNT     = 6;
    // Layout of the visible debug status word.
    localparam int          ST_W        = 8;
    localparam logic [ST_W-1:0] ST_RESET = 8'h00;
    localparam logic        RST_LVL     = 1'b0;
    typedef enum logic [2:0] {
        CDRC_SRC_NONE, CDRC_SRC_EXT, CDRC_SRC_SW, CDRC_SRC_CR, CDRC_SRC_TRG
    } cdrc_src_t;
    typedef enum logic [1:0] {
        CDRC_ACC_IDLE, CDRC_ACC_STEAL, CDRC_ACC_DONE
    } cdrc_acc_t;
endpackage

// ===== hdl/cdrc_run_ctrl.sv
// Core debug run control: event actions, halt and step, and stolen-cycle access.
`timescale 1ns/100ps
module cdrc_run_ctrl
    import cdrc_pkg::*;
(
    input  wire logic                 MCLK,
    input  wire logic                 RST_B,
    input  wire logic                 DEBUG_ENABLE_BIT,
    input  wire logic                 BRK_IN,
    input  wire logic                 SUSPEND_STATE_FIELD_IN,
    input  wire logic                 INSTR_VALID,
    input  wire logic                 INSTR_IS_DEBUG,
    input  wire logic                 INSTR_IS_CR_MOVE,
    input  wire logic [CR_ADDR_W-1:0] INSTR_CR_ADDR,
    input  wire logic                 TRG_HIT,
    input  wire logic [ACT_W-1:0]     EXT_ACT,
    input  wire logic [ACT_W-1:0]     SW_ACT,
    input  wire logic [ACT_W-1:0]     CR_ACT,
    input  wire logic [ACT_W-1:0]     TRG_ACT,
    input  wire logic                 STEP_EN,
    input  wire logic                 RESUME,
    input  wire logic                 SUSPEND_STATE_FIELD_WR,
    input  wire logic                 SUSPEND_STATE_FIELD_WDATA,
    input  wire logic                 BUS_REQ,
    input  wire logic                 BUS_AUTH,
    input  wire logic                 BUS_WR,
    input  wire logic [ADDR_W-1:0]    BUS_ADDR,
    input  wire logic [DATA_W-1:0]    BUS_WDATA,
    input  wire logic                 CORE_ACC_DONE,
    input  wire logic [DATA_W-1:0]    CORE_ACC_RDATA,
    output logic                      BRK_OUT,
    output logic                      SUSPEND_STATE_FIELD_OUT,
    output logic                      HALTED,
    output logic                      BKPT_TRAP,
    output logic                      BKPT_INT,
    output logic                      CNT_RUN,
    output logic [ST_W-1:0]           DEBUG_STATUS,
    output logic                      CORE_ACC_REQ,
    output logic                      CORE_ACC_WR,
    output logic [ADDR_W-1:0]         CORE_ACC_ADDR,
    output logic [DATA_W-1:0]         CORE_ACC_WDATA,
    output logic                      BUS_ACK,
    output logic                      BUS_ERR,
    output logic [DATA_W-1:0]         BUS_RDATA
);
    typedef struct packed {
        logic              brk_out;
        logic              suspend_state_field;
        logic              prevsusp;
        logic              pevt;
        cdrc_src_t         evtsrc;
        logic              halted;
        logic              trap;
        logic              intr;
        logic              cnt_run;
        logic              step_armed;
        cdrc_acc_t         acc;
        logic              acc_req;
        logic              acc_wr;
        logic [ADDR_W-1:0] acc_addr;
        logic [DATA_W-1:0] acc_wdata;
        logic              ack;
        logic              err;
        logic [DATA_W-1:0] rdata;
    } cdrc_ctl_st_t;

    cdrc_ctl_st_t st_r;
    cdrc_ctl_st_t st_nxt;

    cdrc_evt_if evt_if ();

    function automatic logic [ACT_W-1:0] act_of(input cdrc_src_t s,
                                                 input logic [ACT_W-1:0] ext_a,
                                                 input logic [ACT_W-1:0] sw_a,
                                                 input logic [ACT_W-1:0] cr_a,
                                                 input logic [ACT_W-1:0] trg_a);
        logic [ACT_W-1:0] r;
        case (s)
            CDRC_SRC_EXT: r = ext_a;
            CDRC_SRC_SW:  r = sw_a;
            CDRC_SRC_CR:  r = cr_a;
            CDRC_SRC_TRG: r = trg_a;
            default:      r = '0;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Event detector.
    cdrc_event_det u_det (
        .clk              (MCLK),
        .rst_b            (RST_B),
        .enable           (DEBUG_ENABLE_BIT),
        .brk_in           (BRK_IN),
        .instr_valid      (INSTR_VALID),
        .instr_is_debug   (INSTR_IS_DEBUG),
        .instr_is_cr_move (INSTR_IS_CR_MOVE),
        .instr_cr_addr    (INSTR_CR_ADDR),
        .trg_hit          (TRG_HIT),
        .evt              (evt_if.det)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        logic [ACT_W-1:0] act;
        logic             ev;
        // Action words are read one cycle after the event, when the registered detector output is valid, so they must not change in between.
        act = act_of(evt_if.src, EXT_ACT, SW_ACT, CR_ACT, TRG_ACT);
        ev  = evt_if.valid && DEBUG_ENABLE_BIT;
        st_nxt         = st_r;
        st_nxt.brk_out = 1'b0;
        st_nxt.trap    = 1'b0;
        st_nxt.intr    = 1'b0;
        st_nxt.ack     = 1'b0;
        st_nxt.err     = 1'b0;

        // Resume and software suspend writes come first so that an event in the same cycle wins.
        if (RESUME && st_r.halted) begin
            st_nxt.halted     = 1'b0;
            st_nxt.pevt       = 1'b0;
            st_nxt.step_armed = STEP_EN;
        end
        if (SUSPEND_STATE_FIELD_WR) begin
            st_nxt.suspend_state_field = SUSPEND_STATE_FIELD_WDATA;
        end
        if (st_r.step_armed && !st_r.halted && INSTR_VALID) begin
            st_nxt.halted     = DEBUG_ENABLE_BIT;
            st_nxt.step_armed = 1'b0;
        end
        if (SUSPEND_STATE_FIELD_IN && DEBUG_ENABLE_BIT) begin
            st_nxt.halted = 1'b1;
        end

        if (ev) begin
            st_nxt.evtsrc   = evt_if.src;
            st_nxt.pevt     = st_r.halted;
            st_nxt.prevsusp = st_r.suspend_state_field;
            if (act[ACT_SUSPSET]) begin
                st_nxt.suspend_state_field = act[ACT_SUSPVAL];
            end
            st_nxt.brk_out = act[ACT_BRKOUT];
            if (act[ACT_HALT]) begin
                st_nxt.halted = 1'b1;
            end
            st_nxt.trap = act[ACT_TRAP] && !st_r.halted;
            st_nxt.intr = act[ACT_INT] && !st_r.halted;
            if (act[ACT_CNT]) begin
                st_nxt.cnt_run = !st_r.cnt_run;
            end
        end
        if (!DEBUG_ENABLE_BIT) begin
            st_nxt.halted     = 1'b0;
            st_nxt.step_armed = 1'b0;
        end

        // Address-mapped access to core resources, served by stolen cycles.
        case (st_r.acc)
            CDRC_ACC_IDLE: begin
                if (BUS_REQ) begin
                    if (BUS_AUTH) begin
                        st_nxt.acc       = CDRC_ACC_STEAL;
                        st_nxt.acc_req   = 1'b1;
                        st_nxt.acc_wr    = BUS_WR;
                        st_nxt.acc_addr  = BUS_ADDR;
                        st_nxt.acc_wdata = BUS_WDATA;
                    end else begin
                        st_nxt.ack   = 1'b1;
                        st_nxt.err   = 1'b1;
                        st_nxt.rdata = '0;
                    end
                end
            end
            CDRC_ACC_STEAL: begin
                if (CORE_ACC_DONE) begin
                    st_nxt.acc   = CDRC_ACC_DONE;
                    st_nxt.acc_req = 1'b0;
                    st_nxt.ack   = 1'b1;
                    st_nxt.rdata = st_r.acc_wr ? '0 : CORE_ACC_RDATA;
                end
            end
            CDRC_ACC_DONE: begin
                // One idle cycle lets the requester drop its request.
                st_nxt.acc = CDRC_ACC_IDLE;
            end
            default: begin
                st_nxt.acc     = CDRC_ACC_IDLE;
                st_nxt.acc_req = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge MCLK) begin
        if (RST_B == RST_LVL) begin
            st_r <= '{brk_out: 1'b0, suspend_state_field: 1'b0, prevsusp: 1'b0, pevt: 1'b0,
                      evtsrc: CDRC_SRC_NONE, halted: 1'b0, trap: 1'b0, intr: 1'b0,
                      cnt_run: 1'b0, step_armed: 1'b0, acc: CDRC_ACC_IDLE, acc_req: 1'b0,
                      acc_wr: 1'b0, acc_addr: '0, acc_wdata: '0,
                      ack: 1'b0, err: 1'b0, rdata: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register.
    assign BRK_OUT        = st_r.brk_out;
    assign SUSPEND_STATE_FIELD_OUT       = st_r.suspend_state_field;
    assign HALTED         = st_r.halted;
    assign BKPT_TRAP      = st_r.trap;
    assign BKPT_INT       = st_r.intr;
    assign CNT_RUN        = st_r.cnt_run;
    assign DEBUG_STATUS   = {st_r.halted, st_r.evtsrc, st_r.pevt, st_r.prevsusp,
                             st_r.suspend_state_field, st_r.step_armed};
    assign CORE_ACC_REQ   = st_r.acc_req;
    assign CORE_ACC_WR    = st_r.acc_wr;
    assign CORE_ACC_ADDR  = st_r.acc_addr;
    assign CORE_ACC_WDATA = st_r.acc_wdata;
    assign BUS_ACK        = st_r.ack;
    assign BUS_ERR        = st_r.err;
    assign BUS_RDATA      = st_r.rdata;
endmodule // cdrc_run_ctrl

// ===== tb/cdrc_core_model.sv
// Core side model answering stolen access cycles with a settable latency.
`timescale 1ns/100ps
module cdrc_core_model
    import cdrc_pkg::*;
(
    input  wire logic              MCLK,
    input  wire logic              RST_B,
    input  wire logic [3:0]        LAT,
    input  wire logic              CORE_ACC_REQ,
    input  wire logic              CORE_ACC_WR,
    input  wire logic [ADDR_W-1:0] CORE_ACC_ADDR,
    input  wire logic [DATA_W-1:0] CORE_ACC_WDATA,
    output logic                   CORE_ACC_DONE,
    output logic [DATA_W-1:0]      CORE_ACC_RDATA
);
    logic [DATA_W-1:0] mem [16];
    logic [3:0]        cnt;
    // Read data is scrambled every cycle outside reset and the answer cycle.
    always @(posedge MCLK) begin
        CORE_ACC_RDATA <= ~CORE_ACC_RDATA;
        if (!RST_B || CORE_ACC_DONE || !CORE_ACC_REQ) begin
            CORE_ACC_DONE <= 1'b0;
            cnt           <= 4'h0;
            if (!RST_B) CORE_ACC_RDATA <= 32'h0;
        end else if (cnt >= LAT) begin
            CORE_ACC_DONE  <= 1'b1;
            CORE_ACC_RDATA <= mem[CORE_ACC_ADDR[5:2]];
            if (CORE_ACC_WR) mem[CORE_ACC_ADDR[5:2]] <= CORE_ACC_WDATA;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule // cdrc_core_model

// ===== tb/cdrc_run_ctrl_sva.sv
// Concurrent checks on the ports of the core debug run control block.
`timescale 1ns/100ps
module cdrc_run_ctrl_sva
    import cdrc_pkg::*;
(
    input wire logic                 MCLK,
    input wire logic                 RST_B,
    input wire logic                 DEBUG_ENABLE_BIT,
    input wire logic                 BRK_IN,
    input wire logic                 SUSPEND_STATE_FIELD_IN,
    input wire logic                 INSTR_VALID,
    input wire logic                 INSTR_IS_DEBUG,
    input wire logic                 INSTR_IS_CR_MOVE,
    input wire logic                 TRG_HIT,
    input wire logic                 SUSPEND_STATE_FIELD_WR,
    input wire logic                 SUSPEND_STATE_FIELD_WDATA,
    input wire logic                 BUS_REQ,
    input wire logic                 BUS_AUTH,
    input wire logic                 CORE_ACC_DONE,
    input wire logic                 BRK_OUT,
    input wire logic                 SUSPEND_STATE_FIELD_OUT,
    input wire logic                 HALTED,
    input wire logic                 CORE_ACC_REQ,
    input wire logic                 BUS_ACK,
    input wire logic                 BUS_ERR,
    input wire logic [CR_ADDR_W-1:0] INSTR_CR_ADDR,
    input wire logic [ACT_W-1:0]     EXT_ACT,
    input wire logic [ST_W-1:0]      DEBUG_STATUS
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    logic de;
    logic quiet;
    logic cr_in;
    assign de    = DEBUG_ENABLE_BIT;
    assign quiet = !BRK_IN && !TRG_HIT && !INSTR_VALID;
    assign cr_in = (INSTR_CR_ADDR >= DBG_CR_LO) && (INSTR_CR_ADDR <= DBG_CR_HI);
    a_ext_brk_out: assert property ($rose(BRK_IN) && de && EXT_ACT[ACT_BRKOUT] ##1 de && EXT_ACT[ACT_BRKOUT]
        |=> BRK_OUT)
        else $error("break-out missing after break-in");
    a_brk_out_enabled: assert property (BRK_OUT |-> $past(de) && $past(de, 2))
        else $error("break-out while controller disabled");
    a_suspend_in_halt: assert property (de && SUSPEND_STATE_FIELD_IN |=> HALTED)
        else $error("suspend-in did not halt");
    a_suspend_state_field_mirror: assert property (SUSPEND_STATE_FIELD_OUT == DEBUG_STATUS[1])
        else $error("suspend-out differs from suspend field");
    a_suspend_state_field_hold: assert property (!$past(SUSPEND_STATE_FIELD_WR) && !$past(de) |-> $stable(SUSPEND_STATE_FIELD_OUT))
        else $error("suspend-out moved without write or event");
    a_suspend_state_field_write: assert property (de && SUSPEND_STATE_FIELD_WR && quiet && $past(quiet) |=> SUSPEND_STATE_FIELD_OUT == $past(SUSPEND_STATE_FIELD_WDATA))
        else $error("suspend write not seen on suspend-out");
    a_sw_event_src: assert property (de && INSTR_VALID && INSTR_IS_DEBUG && !$rose(BRK_IN) ##1 de
        |=> DEBUG_STATUS[6:4] == 3'h2)
        else $error("debug instruction event source wrong");
    a_cr_event_src: assert property (de && INSTR_VALID && INSTR_IS_CR_MOVE && !INSTR_IS_DEBUG && !cr_in
        && !$rose(BRK_IN) ##1 de |=> DEBUG_STATUS[6:4] == 3'h3)
        else $error("register move event source wrong");
    a_step_halt: assert property (de && !HALTED && DEBUG_STATUS[0] && INSTR_VALID |=> HALTED)
        else $error("single step did not halt");
    a_acc_authorised: assert property ($rose(CORE_ACC_REQ) |-> $past(BUS_REQ) && $past(BUS_AUTH))
        else $error("stolen cycle without authorised request");
    a_acc_done_ack: assert property (CORE_ACC_REQ && CORE_ACC_DONE |=> BUS_ACK && !BUS_ERR && !CORE_ACC_REQ)
        else $error("completed stolen cycle not acknowledged");
    a_bus_refused: assert property (BUS_ERR |-> BUS_ACK && !$past(BUS_AUTH))
        else $error("error answer without refused request");
endmodule // cdrc_run_ctrl_sva

bind cdrc_run_ctrl cdrc_run_ctrl_sva u_cdrc_run_ctrl_sva (.*);

// ===== tb/cdrc_run_ctrl_tb_top.sv
// Self-checking bench of the core debug run control block.
`timescale 1ns/100ps
module cdrc_run_ctrl_tb_top import cdrc_pkg::*; ();
    logic MCLK, RST_B, DEBUG_ENABLE_BIT, BRK_IN, SUSPEND_STATE_FIELD_IN, INSTR_VALID, INSTR_IS_DEBUG, INSTR_IS_CR_MOVE;
    logic TRG_HIT, STEP_EN, RESUME, SUSPEND_STATE_FIELD_WR, SUSPEND_STATE_FIELD_WDATA, BUS_REQ, BUS_AUTH, BUS_WR, CORE_ACC_DONE;
    logic BRK_OUT, SUSPEND_STATE_FIELD_OUT, HALTED, BKPT_TRAP, BKPT_INT, CNT_RUN, CORE_ACC_REQ, CORE_ACC_WR, BUS_ACK, BUS_ERR;
    logic [CR_ADDR_W-1:0] INSTR_CR_ADDR;
    logic [ACT_W-1:0]     EXT_ACT, SW_ACT, CR_ACT, TRG_ACT;
    logic [ST_W-1:0]      DEBUG_STATUS;
    logic [ADDR_W-1:0]    BUS_ADDR, CORE_ACC_ADDR;
    logic [DATA_W-1:0]    BUS_WDATA, BUS_RDATA, CORE_ACC_WDATA, CORE_ACC_RDATA;
    logic [3:0]           LAT;
    int                   failures, samples_checked;
    cdrc_run_ctrl   u_cdrc_run_ctrl   (.*);
    cdrc_core_model u_cdrc_core_model (.*);
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge MCLK);
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic summarize();
        if (failures == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Retires one instruction; returns in the cycle where its actions show.
    task automatic instr(input logic dbg, input logic cr, input logic [15:0] adr);
        INSTR_VALID = 1'b1;
        INSTR_IS_DEBUG = dbg;
        INSTR_IS_CR_MOVE = cr;
        INSTR_CR_ADDR = adr;
        cyc(1);
        {INSTR_VALID, INSTR_IS_DEBUG, INSTR_IS_CR_MOVE} = 3'h0;
        cyc(1);
    endtask
    task automatic resume();
        RESUME = 1'b1;
        cyc(1);
        RESUME = 1'b0;
    endtask
    task automatic bus(input logic auth, wr, input logic [31:0] adr, wd, input logic err, input logic [31:0] rd);
        int n = 0;
        cyc(1);
        {BUS_REQ, BUS_AUTH, BUS_WR, BUS_ADDR, BUS_WDATA} = {1'b1, auth, wr, adr, wd};
        do begin
            cyc(1);
            n++;
        end while (BUS_ACK !== 1'b1 && n < 40);
        chk("bus ack", 1, BUS_ACK);
        chk("bus err", err, BUS_ERR);
        chk("bus rdata", rd, BUS_RDATA);
        BUS_REQ = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_disabled();
        {EXT_ACT, SW_ACT, TRG_ACT} = {3{7'h39}};
        BRK_IN = 1'b1;
        TRG_HIT = 1'b1;
        instr(1'b1, 1'b0, 16'h0000);
        {BRK_IN, TRG_HIT} = 2'h0;
        repeat (4) begin
            cyc(1);
            chk("off actions", 0, {BRK_OUT, HALTED, BKPT_TRAP, BKPT_INT, CNT_RUN});
        end
    endtask
    task automatic t_ext();
        DEBUG_ENABLE_BIT = 1'b1;
        EXT_ACT = 7'h01;
        cyc(1);
        BRK_IN = 1'b1;
        cyc(2);
        chk("brk out", 1, BRK_OUT);
        chk("ext source", 1, DEBUG_STATUS[6:4]);
        cyc(1);
        chk("brk out end", 0, BRK_OUT);
        BRK_IN = 1'b0;
    endtask
    task automatic t_cr();
        logic [15:0] adr [4] = '{16'hefff, 16'hf000, 16'hfdff, 16'hfe00};
        CR_ACT = 7'h01;
        foreach (adr[i]) begin
            instr(1'b0, 1'b1, adr[i]);
            chk("cr brk out", (i == 0 || i == 3), BRK_OUT);
        end
    endtask
    task automatic t_act();
        TRG_ACT = 7'h56;
        TRG_HIT = 1'b1;
        cyc(1);
        TRG_HIT = 1'b0;
        cyc(1);
        chk("trig actions", 4'hf, {BKPT_TRAP, SUSPEND_STATE_FIELD_OUT, CNT_RUN, BKPT_INT == 1'b0});
        chk("trig source", 4, DEBUG_STATUS[6:4]);
        SW_ACT = 7'h20;
        instr(1'b1, 1'b0, 16'h0000);
        chk("sw interrupt", 2'b10, {BKPT_INT, HALTED});
        SW_ACT = 7'h08;
        instr(1'b1, 1'b0, 16'h0000);
        chk("sw halt", 1, HALTED);
        resume();
        chk("resumed", 0, HALTED);
    endtask
    task automatic t_suspend_state_field();
        for (int v = 0; v < 2; v++) begin
            cyc(1);
            SUSPEND_STATE_FIELD_WDATA = v[0];
            SUSPEND_STATE_FIELD_WR = 1'b1;
            cyc(1);
            SUSPEND_STATE_FIELD_WR = 1'b0;
            chk("suspend_state_field out", v, SUSPEND_STATE_FIELD_OUT);
            chk("brk out no write", 0, BRK_OUT);
        end
    endtask
    task automatic t_step();
        SUSPEND_STATE_FIELD_IN = 1'b1;
        cyc(1);
        SUSPEND_STATE_FIELD_IN = 1'b0;
        chk("suspend in halt", 1, HALTED);
        STEP_EN = 1'b1;
        resume();
        chk("step armed", 2'b01, {HALTED, DEBUG_STATUS[0]});
        instr(1'b0, 1'b0, 16'h0000);
        chk("step halt", 1, HALTED);
        STEP_EN = 1'b0;
        resume();
        chk("run again", 0, HALTED);
    endtask
    task automatic t_bus();
        bus(1'b1, 1'b1, 32'h0000_0008, 32'h5a5a_0f0f, 1'b0, 32'h0);
        LAT = 4'h3;
        bus(1'b1, 1'b0, 32'h0000_0008, 32'h0, 1'b0, 32'h5a5a_0f0f);
        bus(1'b0, 1'b0, 32'h0000_0008, 32'h0, 1'b1, 32'h0);
    endtask
    initial begin
        {RST_B, DEBUG_ENABLE_BIT, BRK_IN, SUSPEND_STATE_FIELD_IN, INSTR_VALID, INSTR_IS_DEBUG, INSTR_IS_CR_MOVE, TRG_HIT,
         STEP_EN, RESUME, SUSPEND_STATE_FIELD_WR, SUSPEND_STATE_FIELD_WDATA, BUS_REQ, BUS_AUTH, BUS_WR, INSTR_CR_ADDR, EXT_ACT, SW_ACT,
         CR_ACT, TRG_ACT, BUS_ADDR, BUS_WDATA, LAT} = '0;
        cyc(20);
        RST_B = 1'b1;
        chk("reset outputs", 0, {BRK_OUT, SUSPEND_STATE_FIELD_OUT, HALTED, BKPT_TRAP, CORE_ACC_REQ, BUS_ACK, DEBUG_STATUS});
        t_disabled();
        t_ext();
        t_cr();
        t_act();
        t_suspend_state_field();
        t_step();
        t_bus();
        summarize();
    end
    initial begin
        #20000;
        failures++;
        summarize();
    end
endmodule // cdrc_run_ctrl_tb_top
